// File: rtl/usp_pkg.sv
package usp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned                   CLK_MHZ       = 250;
  localparam int unsigned                   OSC_START_US  = 2;
  localparam int unsigned                   OSC_START_CYC = OSC_START_US * CLK_MHZ;
  localparam int unsigned                   OSC_CNT_W     = $clog2(OSC_START_CYC);
  localparam logic [OSC_CNT_W-1:0]          OSC_LAST      = OSC_CNT_W'(OSC_START_CYC - 1);
  localparam longint unsigned               PUMP_IDLE_S   = 30;
  localparam int unsigned                   PUMP_CNT_W    = 33;
  localparam logic [PUMP_CNT_W-1:0]         PUMP_IDLE_CYC =
    PUMP_CNT_W'(PUMP_IDLE_S * 64'(CLK_MHZ) * 64'd1_000_000);

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam int unsigned                   ADDR_W      = 8;
  localparam logic [ADDR_W-1:0]             OFF_IER     = 8'h00;
  localparam logic [ADDR_W-1:0]             OFF_ISR     = 8'h04;
  localparam logic [ADDR_W-1:0]             OFF_DIV     = 8'h08;
  localparam logic [ADDR_W-1:0]             OFF_MSR     = 8'h0C;
  localparam logic [ADDR_W-1:0]             OFF_THR     = 8'h10;
  localparam logic [ADDR_W-1:0]             OFF_STAT    = 8'h14;
  localparam logic [ADDR_W-1:0]             OFF_IRQ_ST  = 8'h18;
  localparam logic [ADDR_W-1:0]             OFF_IRQ_CLR = 8'h1C;
  localparam logic [ADDR_W-1:0]             OFF_IRQ_EN  = 8'h20;

  localparam int unsigned                   IER_SLEEP_BIT = 4;
  localparam logic [7:0]                    IER_MASK      = 8'h3F;
  localparam logic [7:0]                    IER_RST       = 8'h00;
  localparam logic [15:0]                   DIV_RST       = 16'h0000;
  localparam logic [3:0]                    ISR_NONE      = 4'h1;

  localparam int unsigned                   EV_WAKE     = 0;
  localparam int unsigned                   EV_PUMP_OFF = 1;
  localparam int unsigned                   EV_PUMP_ON  = 2;
  localparam int unsigned                   EV_PSAVE    = 3;
  localparam int unsigned                   EV_W        = 4;
  localparam logic [EV_W-1:0]               IRQ_EN_RST  = 4'h0;

  localparam logic [1:0]                    RESP_OKAY   = 2'h0;
  localparam logic [1:0]                    RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {MODE_ACTIVE, MODE_SLEEP, MODE_WAKING} usp_mode_t;

  typedef struct packed {
    logic       iso;
    logic       auto_pump_shutdown_pin;
    logic [3:0] modem;
    logic [1:0] rx;
  } usp_pins_t;

  localparam usp_pins_t PIN_RST = '{iso: 1'h0, auto_pump_shutdown_pin: 1'h0, modem: 4'h0, rx: 2'h3};

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } usp_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } usp_axi_rsp_t;

  localparam usp_axi_rsp_t RSP_RST = '{awready: 1'h1, wready: 1'h1, arready: 1'h1,
                                       default: '0};

endpackage

// File: rtl/usp_sync3.sv
module usp_sync3 #(
  parameter int unsigned   W       = 1,
  parameter logic [W-1:0]  RST_VAL = '0
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_stable
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } usp_sync_st_t;

  usp_sync_st_t q;
  usp_sync_st_t next_q;

  // a change counts once stages two and three agree
  always_comb begin
    next_q    = q;
    next_q.s1 = i_async;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        next_q.stable[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, stable: RST_VAL};
    end else begin
      q <= next_q;
    end
  end

  assign o_stable = q.stable;

endmodule

// File: rtl/usp_power_ctrl.sv
//////////////////////////////////////////////////////////////////////////////
// Operation
// [R1] sleep needs enable bit and nothing pending
// [R2] sleep needs non-zero baud divisor
// [R3] sleep needs clear modem deltas, idle rx
// [R4] asleep: crystal oscillator stopped
// [R5] wake on start bit, tx write, modem
// [R6] wake raises source 0x1, read clears
// [R7] re-enter sleep once everything serviced
// [R8] host reads modem status after modem wake
// [R9] never sleep pending; stay until bit cleared
// [R10] awake: pump off after idle timeout
// [R11] pump off: drivers tri-stated, bus alive
// [R12] pump restarts on rx, tx, modem rise
// [R13] host waits pump recovery before transmitting
// [R14] asleep with pump pin: pump off immediately
// [R15] power-save only asleep; bus blocked
// [R16] power-save wakes only on rx, modem
// [R17] power-save re-entered automatically until released
// [R18] power-save wake interrupt after oscillator ready
// [R19] wake edges detected on free-running clock
//
// Chosen here: register access over AXI4-Lite and the register addresses.
module usp_power_ctrl #(
  parameter logic [usp_pkg::PUMP_CNT_W-1:0] P_PUMP_IDLE = usp_pkg::PUMP_IDLE_CYC
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_rstn,
  input  wire usp_pkg::usp_axi_req_t i_axi,
  output usp_pkg::usp_axi_rsp_t      o_axi,
  input  wire logic [1:0]            i_rx_pin,
  input  wire logic [3:0]            i_modem_pin,
  input  wire logic                  i_auto_pump_shutdown_pin,
  input  wire logic                  i_bus_isolation_pin,
  input  wire logic                  i_tx_active,
  input  wire logic [3:0]            i_core_isr,
  output logic                       o_osc_en,
  output logic                       o_pump_en,
  output logic                       o_driver_oe,
  output logic                       o_bus_isolate,
  output logic                       o_wake_int,
  output logic                       o_irq,
  output logic                       o_tx_wr,
  output logic [7:0]                 o_tx_data
);
  import usp_pkg::*;

  typedef struct packed {
    usp_mode_t               mode;
    logic [OSC_CNT_W-1:0]    osc_cnt;
    logic [PUMP_CNT_W-1:0]   idle_cnt;
    logic                    pump_off;
    logic                    wake_pend;
    logic [7:0]              interrupt_enable_reg;
    logic [15:0]             div;
    logic [3:0]              msr_delta;
    logic [EV_W-1:0]         irq_st;
    logic [EV_W-1:0]         irq_en;
    usp_pins_t               pins_q;
    logic                    aw_held;
    logic [ADDR_W-1:0]       aw_addr;
    logic                    w_held;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    usp_axi_rsp_t            rsp;
    logic                    tx_wr;
    logic [7:0]              tx_data;
    logic                    osc_en;
    logic                    pump_en;
    logic                    drv_oe;
    logic                    bus_iso;
    logic                    wake_int;
    logic                    irq;
  } usp_state_t;

  localparam usp_state_t ST_RST = '{mode: MODE_ACTIVE, interrupt_enable_reg: IER_RST, div: DIV_RST,
                                    irq_en: IRQ_EN_RST, pins_q: PIN_RST, rsp: RSP_RST,
                                    osc_en: 1'h1, pump_en: 1'h1, drv_oe: 1'h1,
                                    default: '0};

  usp_state_t      q;
  usp_state_t      next_q;
  usp_pins_t       pins;
  logic [1:0]      rx_fall;
  logic [1:0]      rx_rise;
  logic [3:0]      mod_chg;
  logic [3:0]      mod_rise;
  logic            wr_go;
  logic            wr_ok;
  logic            wr_hit;
  logic            thr_wr;
  logic            rd_go;
  logic            rd_ok;
  logic            rd_isr;
  logic            rd_msr;
  logic [EV_W-1:0] irq_clr;
  logic [EV_W-1:0] ev;
  logic [3:0]      isr_code;
  logic            pend;
  logic            sleep_ok;
  logic            wake_now;
  logic            pump_wake;
  logic [31:0]     rd_data;
  logic [1:0]      rd_resp;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  usp_sync3 #(
    .W       ($bits(usp_pins_t)),
    .RST_VAL (PIN_RST)
  ) u_pin_sync (
    .i_mclk   (i_mclk),
    .i_rstn   (i_rstn),
    .i_async  ({i_bus_isolation_pin, i_auto_pump_shutdown_pin, i_modem_pin, i_rx_pin}),
    .o_stable (pins)
  );

  // [R19] edges on running clock
  assign rx_fall  = q.pins_q.rx & ~pins.rx;
  assign rx_rise  = ~q.pins_q.rx & pins.rx;
  assign mod_chg  = q.pins_q.modem ^ pins.modem;
  assign mod_rise = ~q.pins_q.modem & pins.modem;

  //////////////////////////////////////////////////////////////////////////////
  // bus decode
  // [R15] isolated bus has no effect
  assign wr_go   = q.aw_held && q.w_held && !q.rsp.bvalid;
  assign wr_ok   = wr_go && !q.bus_iso;
  assign wr_hit  = q.aw_addr inside {OFF_IER, OFF_ISR, OFF_DIV, OFF_MSR, OFF_THR,
                                     OFF_STAT, OFF_IRQ_ST, OFF_IRQ_CLR, OFF_IRQ_EN};
  // [R16] blocked tx write cannot wake
  assign thr_wr  = wr_ok && (q.aw_addr == OFF_THR) && q.w_strb[0];
  assign irq_clr = (wr_ok && (q.aw_addr == OFF_IRQ_CLR) && q.w_strb[0]) ?
                   q.w_data[EV_W-1:0] : '0;
  assign rd_go   = i_axi.arvalid && q.rsp.arready;
  assign rd_ok   = rd_go && !q.bus_iso;
  assign rd_isr  = rd_ok && (i_axi.araddr == OFF_ISR) && i_core_isr[0];
  assign rd_msr  = rd_ok && (i_axi.araddr == OFF_MSR);

  // [R6] wake shows as source 0x1
  assign isr_code = i_core_isr[0] ? ISR_NONE : i_core_isr;

  always_comb begin
    rd_data = '0;
    rd_resp = RESP_OKAY;
    case (i_axi.araddr)
      OFF_IER:     rd_data[7:0]      = q.interrupt_enable_reg;
      OFF_ISR:     rd_data[3:0]      = isr_code;
      OFF_DIV:     rd_data[15:0]     = q.div;
      OFF_MSR:     rd_data[7:0]      = {pins.modem, q.msr_delta};
      OFF_STAT:    rd_data[3:0]      = {q.bus_iso, q.pump_off, q.mode == MODE_SLEEP,
                                        q.osc_en};
      OFF_IRQ_ST:  rd_data[EV_W-1:0] = q.irq_st;
      OFF_IRQ_EN:  rd_data[EV_W-1:0] = q.irq_en;
      OFF_THR,
      OFF_IRQ_CLR: rd_data           = '0;
      default:     rd_resp           = RESP_SLVERR;
    endcase
    if (q.bus_iso) begin
      rd_data = '0;
      rd_resp = RESP_SLVERR;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sleep and wake conditions
  // [R9] a pending interrupt blocks sleep
  assign pend     = q.wake_pend || !i_core_isr[0];
  // [R1] enable bit and no pending source
  // [R2] divisor must be non-zero
  // [R3] deltas clear and rx idle
  // [R7] automatic re-entry when clear
  assign sleep_ok = q.interrupt_enable_reg[IER_SLEEP_BIT] && !pend && (q.div != DIV_RST) &&
                    (q.msr_delta == 4'h0) && (&pins.rx);
  // [R5] start bit, tx write, modem change
  assign wake_now = !q.interrupt_enable_reg[IER_SLEEP_BIT] || (|rx_fall) || (|mod_chg) || thr_wr;
  // [R12] pump restart events
  assign pump_wake = (|rx_rise) || (|mod_rise) || thr_wr;

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_q        = q;
    ev            = '0;
    next_q.pins_q = pins;

    // axi write channels
    if (i_axi.awvalid && q.rsp.awready) begin
      next_q.aw_held = 1'h1;
      next_q.aw_addr = i_axi.awaddr;
    end
    if (i_axi.wvalid && q.rsp.wready) begin
      next_q.w_held = 1'h1;
      next_q.w_data = i_axi.wdata;
      next_q.w_strb = i_axi.wstrb;
    end
    if (q.rsp.bvalid && i_axi.bready) next_q.rsp.bvalid = 1'h0;
    if (wr_go) begin
      next_q.aw_held   = 1'h0;
      next_q.w_held    = 1'h0;
      next_q.rsp.bvalid = 1'h1;
      next_q.rsp.bresp  = (wr_hit && !q.bus_iso) ? RESP_OKAY : RESP_SLVERR;
    end
    next_q.rsp.awready = !next_q.aw_held && !next_q.rsp.bvalid;
    next_q.rsp.wready  = !next_q.w_held && !next_q.rsp.bvalid;

    // axi read channels
    if (q.rsp.rvalid && i_axi.rready) next_q.rsp.rvalid = 1'h0;
    if (rd_go) begin
      next_q.rsp.rvalid = 1'h1;
      next_q.rsp.rdata  = rd_data;
      next_q.rsp.rresp  = rd_resp;
    end
    next_q.rsp.arready = !next_q.rsp.rvalid;

    // register writes
    next_q.tx_wr = thr_wr;
    if (thr_wr) next_q.tx_data = q.w_data[7:0];
    if (wr_ok) begin
      case (q.aw_addr)
        OFF_IER:    if (q.w_strb[0]) next_q.interrupt_enable_reg = q.w_data[7:0] & IER_MASK;
        OFF_DIV: begin
          if (q.w_strb[0]) next_q.div[7:0] = q.w_data[7:0];
          if (q.w_strb[1]) next_q.div[15:8] = q.w_data[15:8];
        end
        OFF_IRQ_EN: if (q.w_strb[0]) next_q.irq_en = q.w_data[EV_W-1:0];
        default:    ;
      endcase
    end

    // modem deltas: read clears, a new change wins
    if (rd_msr) next_q.msr_delta = 4'h0;
    next_q.msr_delta = next_q.msr_delta | mod_chg;

    // [R6] isr read clears wake, set wins
    if (rd_isr) next_q.wake_pend = 1'h0;

    // power mode machine
    unique case (q.mode)
      MODE_ACTIVE: if (sleep_ok) next_q.mode = MODE_SLEEP;
      MODE_SLEEP: begin
        // [R9] stay asleep until bit cleared or a start bit, tx write or modem change
        if (wake_now) begin
          next_q.mode    = MODE_WAKING;
          next_q.osc_cnt = '0;
        end
      end
      MODE_WAKING: begin
        // [R18] interrupt once oscillator ready
        if (q.osc_cnt == OSC_LAST) begin
          next_q.mode = MODE_ACTIVE;
          if (q.interrupt_enable_reg[IER_SLEEP_BIT]) begin
            next_q.wake_pend = 1'h1;
            ev[EV_WAKE]      = 1'h1;
          end
        end else begin
          next_q.osc_cnt = q.osc_cnt + OSC_CNT_W'(1);
        end
      end
    endcase

    // [R15] isolate only while asleep
    // [R17] isolation follows sleep re-entry
    next_q.bus_iso = (next_q.mode == MODE_SLEEP) && pins.iso && next_q.interrupt_enable_reg[IER_SLEEP_BIT];
    if (next_q.bus_iso && !q.bus_iso) ev[EV_PSAVE] = 1'h1;

    // charge pump control
    if (!pins.auto_pump_shutdown_pin) begin
      next_q.pump_off = 1'h0;
      next_q.idle_cnt = '0;
    end else if (q.pump_off) begin
      // [R12] restart on rx, tx, modem rise
      if (pump_wake) begin
        next_q.pump_off = 1'h0;
        next_q.idle_cnt = '0;
      end
    end else if (q.mode == MODE_SLEEP) begin
      // [R14] asleep: immediate shutdown
      next_q.pump_off = 1'h1;
    end else if (i_tx_active || (|mod_chg)) begin
      next_q.idle_cnt = '0;
    end else if (q.idle_cnt >= P_PUMP_IDLE - PUMP_CNT_W'(1)) begin
      // [R10] idle timeout shutdown
      next_q.pump_off = 1'h1;
      next_q.idle_cnt = '0;
    end else begin
      next_q.idle_cnt = q.idle_cnt + PUMP_CNT_W'(1);
    end
    if (next_q.pump_off && !q.pump_off) ev[EV_PUMP_OFF] = 1'h1;
    if (!next_q.pump_off && q.pump_off) ev[EV_PUMP_ON] = 1'h1;

    // sticky events, set wins over clear
    next_q.irq_st = (q.irq_st & ~irq_clr) | ev;
    next_q.irq    = |(next_q.irq_st & next_q.irq_en);

    // [R4] oscillator off while asleep
    next_q.osc_en   = next_q.mode != MODE_SLEEP;
    next_q.pump_en  = !next_q.pump_off;
    // [R11] drivers released with pump off
    next_q.drv_oe   = !next_q.pump_off;
    // [R18] wake visible with no other enable
    next_q.wake_int = next_q.wake_pend && (next_q.interrupt_enable_reg[3:0] == 4'h0);
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= ST_RST;
    end else begin
      q <= next_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_axi         = q.rsp;
  assign o_osc_en      = q.osc_en;
  assign o_pump_en     = q.pump_en;
  assign o_driver_oe   = q.drv_oe;
  assign o_bus_isolate = q.bus_iso;
  assign o_wake_int    = q.wake_int;
  assign o_irq         = q.irq;
  assign o_tx_wr       = q.tx_wr;
  assign o_tx_data     = q.tx_data;

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_enter_sleep;
    q.mode == MODE_ACTIVE ##1 q.mode == MODE_SLEEP;
  endsequence

  sequence s_wake_done;
    (q.mode == MODE_WAKING && q.interrupt_enable_reg[IER_SLEEP_BIT]) ##1 q.mode == MODE_ACTIVE;
  endsequence

  a_sleep_entry_enable: assert property ( // [R1]
    s_enter_sleep |-> $past(q.interrupt_enable_reg[IER_SLEEP_BIT]) && !$past(q.wake_pend) &&
                      $past(i_core_isr[0]))
    else $error("sleep entered without enable or with interrupt pending");
  a_sleep_entry_div: assert property ( // [R2]
    s_enter_sleep |-> $past(q.div) != DIV_RST)
    else $error("sleep entered with zero divisor");
  a_sleep_entry_lines: assert property ( // [R3]
    s_enter_sleep |-> $past(q.msr_delta) == 4'h0 && $past(&pins.rx))
    else $error("sleep entered with modem delta or busy rx");
  a_osc_stopped: assert property ( // [R4]
    q.mode == MODE_SLEEP |-> !o_osc_en)
    else $error("oscillator running while asleep");
  a_wake_on_start: assert property ( // [R5]
    (q.mode == MODE_SLEEP && (|rx_fall)) |=> q.mode == MODE_WAKING)
    else $error("start bit did not wake");
  a_wake_int_set: assert property ( // [R6]
    s_wake_done |-> q.wake_pend && q.irq_st[EV_WAKE])
    else $error("wake interrupt missing after oscillator start");
  a_pump_sleep_off: assert property ( // [R14]
    (q.mode == MODE_SLEEP && pins.auto_pump_shutdown_pin && !q.pump_off && !pump_wake) |=> !o_pump_en)
    else $error("pump not shut down while asleep");
  a_driver_off: assert property ( // [R11]
    q.pump_off |-> !o_driver_oe && !o_pump_en)
    else $error("drivers enabled with pump off");
  a_psave_no_bus: assert property ( // [R16]
    (q.bus_iso && !(|rx_fall) && !(|mod_chg)) |=> q.mode == MODE_SLEEP && !q.tx_wr)
    else $error("power-save left without line event");
  a_wake_after_osc: assert property ( // [R18]
    $rose(q.wake_pend) |-> $past(q.mode) == MODE_WAKING && $past(q.osc_cnt) == OSC_LAST)
    else $error("wake interrupt before oscillator ready");

endmodule

// File: tb/usp_host.sv
module usp_host
  import usp_pkg::*;
(
  input  wire logic                  i_mclk,
  input  wire usp_pkg::usp_axi_rsp_t i_rsp,
  output usp_pkg::usp_axi_req_t      o_req
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PUMP_REC = 45 * CLK_MHZ;
  logic hung;
  initial begin
    o_req = '0;
    hung  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int   n;
    logic aw;
    logic w;
    aw = 1'b1;
    w  = 1'b1;
    r  = 2'h3;
    @(posedge i_mclk);
    o_req.awaddr  <= a;
    o_req.wdata   <= d;
    o_req.wstrb   <= 4'hF;
    o_req.awvalid <= 1'b1;
    o_req.wvalid  <= 1'b1;
    o_req.bready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge i_mclk);
      if (aw && i_rsp.awready) begin
        o_req.awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && i_rsp.wready) begin
        o_req.wvalid <= 1'b0;
        w = 1'b0;
      end
      if (i_rsp.bvalid) begin
        r = i_rsp.bresp;
        break;
      end
    end
    o_req.bready <= 1'b0;
    if (n == 200) hung = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // one read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ar;
    ar = 1'b1;
    r  = 2'h3;
    d  = '0;
    @(posedge i_mclk);
    o_req.araddr  <= a;
    o_req.arvalid <= 1'b1;
    o_req.rready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge i_mclk);
      if (ar && i_rsp.arready) begin
        o_req.arvalid <= 1'b0;
        ar = 1'b0;
      end
      if (i_rsp.rvalid) begin
        d = i_rsp.rdata;
        r = i_rsp.rresp;
        break;
      end
    end
    o_req.rready <= 1'b0;
    if (n == 200) hung = 1'b1;
  endtask
  task automatic pump_wait();
    repeat (PUMP_REC) @(posedge i_mclk);
  endtask
endmodule

// File: tb/usp_power_ctrl_tb.sv
module usp_power_ctrl_tb;
  import usp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [32:0] PIDLE = 33'd50;
  logic          mclk;
  logic          rstn;
  usp_axi_req_t  req;
  usp_axi_rsp_t  rsp;
  logic [1:0]    rx;
  logic [3:0]    modem;
  logic          auto_pump_shutdown_pin;
  logic          iso;
  logic          tx_act;
  logic [3:0]    core_isr;
  logic          osc_en;
  logic          pump_en;
  logic          drv_oe;
  logic          bus_iso;
  logic          wake_int;
  logic          irq;
  logic          tx_wr;
  logic [7:0]    tx_data;
  int            n_mismatch;
  int            n_checks;
  int            n_tx = 0;
  logic [1:0]    r;

  usp_power_ctrl #(.P_PUMP_IDLE(PIDLE)) dut (
    .i_mclk(mclk), .i_rstn(rstn), .i_axi(req), .o_axi(rsp), .i_rx_pin(rx),
    .i_modem_pin(modem), .i_auto_pump_shutdown_pin(auto_pump_shutdown_pin), .i_bus_isolation_pin(iso),
    .i_tx_active(tx_act), .i_core_isr(core_isr), .o_osc_en(osc_en), .o_pump_en(pump_en),
    .o_driver_oe(drv_oe), .o_bus_isolate(bus_iso), .o_wake_int(wake_int), .o_irq(irq),
    .o_tx_wr(tx_wr), .o_tx_data(tx_data));
  usp_host host (.i_mclk(mclk), .i_rsp(rsp), .o_req(req));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  q;
    host.rd(a, d, q);
    chk({q, d & m}, {RESP_OKAY, e});
  endtask
  task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] q;
    host.wr(a, d, q);
    chk({32'h0, q}, {32'h0, e});
  endtask
  task automatic wt(input int s, input logic v);
    logic [4:0] o;
    for (int n = 0; n < 3000; n++) begin
      @(posedge mclk);
      o = {irq, bus_iso, pump_en, wake_int, osc_en};
      if (o[s] === v) return;
    end
    n_mismatch++;
    $display("BAD %0t wait %0d", $time, s);
    finish_test();
  endtask
  always @(posedge mclk) begin
    if (tx_wr === 1'b1) n_tx++;
    if (host.hung === 1'b1) begin
      n_mismatch++;
      $display("BAD %0t bus hang", $time);
      finish_test();
    end
  end

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    n_mismatch = 0;
    n_checks   = 0;
    rstn = 1'b0;
    rx = 2'h3;
    modem = 4'h0;
    auto_pump_shutdown_pin = 1'b0;
    iso = 1'b0;
    tx_act = 1'b0;
    core_isr = 4'h1;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    rc(OFF_STAT, 32'hF, 32'h1);
    rc(OFF_IER, 32'hFF, 32'h0);
    rc(OFF_DIV, 32'hFFFF, 32'h0);
    host.rd(8'h40, d, r);
    chk({r, d}, {RESP_SLVERR, 32'h0});
    wc(OFF_IER, 32'h10, RESP_OKAY);
    repeat (20) @(posedge mclk);
    chk({33'h0, osc_en}, 34'h1);
    core_isr <= 4'h2;
    wc(OFF_DIV, 32'h1, RESP_OKAY);
    repeat (20) @(posedge mclk);
    chk({33'h0, osc_en}, 34'h1);
    core_isr <= 4'h1;
    wt(0, 1'b0);
    rc(OFF_STAT, 32'h3, 32'h2);
    // transmit write wakes, then interrupt plumbing
    wc(OFF_THR, 32'h5A, RESP_OKAY);
    chk({26'h0, tx_data}, 34'h5A);
    wt(1, 1'b1);
    chk(34'(n_tx), 34'h1);
    rc(OFF_IRQ_ST, 32'h1, 32'h1);
    wc(OFF_IRQ_EN, 32'h1, RESP_OKAY);
    wt(4, 1'b1);
    wc(OFF_IRQ_EN, 32'h0, RESP_OKAY);
    wt(4, 1'b0);
    wc(OFF_IRQ_EN, 32'h1, RESP_OKAY);
    wc(OFF_IRQ_CLR, 32'hF, RESP_OKAY);
    wt(4, 1'b0);
    rc(OFF_IRQ_ST, 32'hF, 32'h0);
    rc(OFF_ISR, 32'hF, 32'h1);
    wt(0, 1'b0);
    // receive start bit wakes
    rx <= 2'h2;
    wt(1, 1'b1);
    rx <= 2'h3;
    rc(OFF_ISR, 32'hF, 32'h1);
    wt(0, 1'b0);
    // modem change wakes, sleep held until status read
    modem <= 4'h1;
    wt(1, 1'b1);
    rc(OFF_ISR, 32'hF, 32'h1);
    repeat (50) @(posedge mclk);
    chk({33'h0, osc_en}, 34'h1);
    rc(OFF_MSR, 32'hFF, 32'h11);
    wt(0, 1'b0);
    // power-save
    iso <= 1'b1;
    wt(3, 1'b1);
    wc(OFF_THR, 32'h11, RESP_SLVERR);
    repeat (20) @(posedge mclk);
    chk({33'h0, osc_en}, 34'h0);
    chk(34'(n_tx), 34'h1);
    rx <= 2'h1;
    wt(1, 1'b1);
    chk({32'h0, osc_en, bus_iso}, 34'h2);
    rx <= 2'h3;
    rc(OFF_ISR, 32'hF, 32'h1);
    wt(3, 1'b1);
    iso <= 1'b0;
    wt(3, 1'b0);
    // charge pump
    auto_pump_shutdown_pin <= 1'b1;
    wt(2, 1'b0);
    chk({33'h0, drv_oe}, 34'h0);
    rc(OFF_STAT, 32'hF, 32'h6);
    wc(OFF_THR, 32'h33, RESP_OKAY);
    wt(2, 1'b1);
    wt(1, 1'b1);
    chk(34'(n_tx), 34'h2);
    chk({26'h0, tx_data}, 34'h33);
    wc(OFF_IER, 32'h0, RESP_OKAY);
    rc(OFF_ISR, 32'hF, 32'h1);
    wt(2, 1'b0);
    chk({33'h0, drv_oe}, 34'h0);
    modem <= 4'h3;
    wt(2, 1'b1);
    tx_act <= 1'b1;
    host.pump_wait();
    chk({33'h0, pump_en}, 34'h1);
    tx_act <= 1'b0;
    wt(2, 1'b0);
    finish_test();
  end
endmodule
